// [include/dsos_defines.svh]
// Constants of the drive stop option select block: object indices,
// subindices, preset values and option code encodings.
// Assumes inclusion by the package and the design modules only.
//
// Operation
// - Velocity deceleration is speed change over time
// - Quick stop in velocity mode uses that ratio
// - Speed to rpm: times numerator, over denominator
// - Scale factors signed 32-bit, RW, mappable, preset one
// - Quick stop code, 16-bit, preset two, applied
// - Code zero: immediate stop, then switch on disabled
// - Codes one/two: slow/quick ramp, then disabled
// - Codes five/six: ramp, stay quick stop energized
// - After five/six, return to operation enabled allowed
// - Shutdown code: zero freewheel, one slow ramp
// - Disable code: zero freewheel, one slow ramp
// - Quick stop codes 0,1,2,5,6 only defined
`ifndef DSOS_DEFINES_SVH
`define DSOS_DEFINES_SVH

// ****************************************************************
// Object indices and subindices
// ****************************************************************
`define DSOS_IDX_VEL_QS_DECEL   16'h604A
`define DSOS_IDX_VEL_SCALE      16'h604C
`define DSOS_IDX_QS_ACTION      16'h605A
`define DSOS_IDX_SHUTDOWN_ACT   16'h605B
`define DSOS_IDX_DISABLE_ACT    16'h605C
`define DSOS_SUB_COUNT          8'h00
`define DSOS_SUB_FIRST          8'h01
`define DSOS_SUB_SECOND         8'h02

// ****************************************************************
// Preset values
// ****************************************************************
`define DSOS_RST_ENTRY_COUNT    8'h02
`define DSOS_RST_SCALE_NUM      32'h0000_0001
`define DSOS_RST_SCALE_DEN      32'h0000_0001
`define DSOS_RST_QS_DSPEED      32'h0000_1388
`define DSOS_RST_QS_DTIME       16'h0001
`define DSOS_RST_QS_ACTION      16'h0002
`define DSOS_RST_SHUTDOWN_ACT   16'h0001
`define DSOS_RST_DISABLE_ACT    16'h0001

// ****************************************************************
// Option code encodings
// ****************************************************************
`define DSOS_CODE_IMMEDIATE     16'h0000
`define DSOS_CODE_SLOW          16'h0001
`define DSOS_CODE_QUICK         16'h0002
`define DSOS_CODE_SLOW_HOLD     16'h0005
`define DSOS_CODE_QUICK_HOLD    16'h0006
`define DSOS_CODE_COAST         16'h0000

// ****************************************************************
// Divider
// ****************************************************************
`define DSOS_DIV_STEPS          7'h40

`endif

// [include/dsos_pkg.sv]
// Types of the drive stop option select block.
// Assumes dsos_defines.svh in the include path.
`include "dsos_defines.svh"

package dsos_pkg;

  typedef enum logic [1:0] {
    DSOS_TR_QUICK_STOP = 2'h0,
    DSOS_TR_SHUTDOWN   = 2'h1,
    DSOS_TR_DISABLE    = 2'h2
  } dsos_trans_t;

  typedef enum logic [2:0] {
    DSOS_BRK_NONE      = 3'h0,
    DSOS_BRK_COAST     = 3'h1,
    DSOS_BRK_IMMEDIATE = 3'h2,
    DSOS_BRK_SLOW      = 3'h3,
    DSOS_BRK_QUICK     = 3'h4
  } dsos_brake_t;

  typedef enum logic [1:0] {
    DSOS_TGT_SWITCH_ON_DISABLED = 2'h0,
    DSOS_TGT_READY_TO_SWITCH_ON = 2'h1,
    DSOS_TGT_SWITCHED_ON        = 2'h2,
    DSOS_TGT_QUICK_STOP_ACTIVE  = 2'h3
  } dsos_target_t;

  typedef enum logic [1:0] {
    DSOS_ST_IDLE = 2'h0,
    DSOS_ST_RAMP = 2'h1,
    DSOS_ST_HELD = 2'h3
  } dsos_state_t;

  typedef struct packed {
    dsos_brake_t  brake;
    dsos_target_t target;
    logic         energized;
    logic         defined;
  } dsos_action_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        pdo;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } dsos_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } dsos_od_rsp_t;

  typedef struct packed {
    logic         ramp_req;
    dsos_brake_t  brake;
    logic         use_vel_ratio;
    logic [31:0]  dec_speed;
    logic [15:0]  dec_time;
    logic         state_chg;
    dsos_target_t target;
    logic         energized;
    logic         resume_ok;
    logic         resume_grant;
    logic         code_err;
  } dsos_stop_cmd_t;

endpackage

// [verilog/dsos_scale.sv]
// Velocity unit scaling: product of speed and numerator, divided by
// the denominator with a serial restoring divider.
// Assumes the caller holds the factors steady while busy is high.
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"

module dsos_scale
  import dsos_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               start,
  input  wire logic [WIDTH-1:0]   speed_in,
  input  wire logic [WIDTH-1:0]   num,
  input  wire logic [WIDTH-1:0]   den,
  output logic                    busy,
  output logic                    done,
  output logic                    div_zero,
  output logic [WIDTH-1:0]        result
);

  typedef struct packed {
    logic               busy;
    logic               done;
    logic               dz;
    logic               neg;
    logic [6:0]         cnt;
    logic [WIDTH:0]     rem;
    logic [2*WIDTH-1:0] quo;
    logic [WIDTH-1:0]   div;
    logic [WIDTH-1:0]   res;
  } dsos_div_t;

  dsos_div_t s_q;
  dsos_div_t s_d;

  function automatic logic [2*WIDTH-1:0] abs_val(input logic [2*WIDTH-1:0] v);
    abs_val = v[2*WIDTH-1] ? (~v + 1'b1) : v;
  endfunction

  logic [2*WIDTH-1:0] prod;
  logic [2*WIDTH-1:0] den_ext;
  logic [2*WIDTH-1:0] den_abs;
  logic [WIDTH:0]     rem_sh;

  // Both factors sign-extended to full product width
  assign prod    = $signed({{WIDTH{speed_in[WIDTH-1]}}, speed_in}) *
                   $signed({{WIDTH{num[WIDTH-1]}}, num});
  assign den_ext = {{WIDTH{den[WIDTH-1]}}, den};
  assign den_abs = abs_val(den_ext);
  assign rem_sh  = {s_q.rem[WIDTH-1:0], s_q.quo[2*WIDTH-1]};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy && start) begin
      // Multiply then divide
      s_d.dz   = (den == '0);
      s_d.neg  = prod[2*WIDTH-1] ^ den[WIDTH-1];
      s_d.quo  = abs_val(prod);
      s_d.div  = den_abs[WIDTH-1:0];
      s_d.rem  = '0;
      s_d.cnt  = `DSOS_DIV_STEPS;
      s_d.busy = (den != '0);
      if (den == '0) begin
        s_d.res  = '0;
        s_d.done = 1'b1;
      end
    end else if (s_q.busy) begin
      s_d.quo = {s_q.quo[2*WIDTH-2:0], 1'b0};
      if (rem_sh >= {1'b0, s_q.div}) begin
        s_d.rem    = rem_sh - {1'b0, s_q.div};
        s_d.quo[0] = 1'b1;
      end else begin
        s_d.rem = rem_sh;
      end
      s_d.cnt = s_q.cnt - 7'h01;
      if (s_q.cnt == 7'h01) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.res  = s_q.neg ? (~s_d.quo[WIDTH-1:0] + 1'b1) : s_d.quo[WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy     = s_q.busy;
  assign done     = s_q.done;
  assign div_zero = s_q.dz;
  assign result   = s_q.res;

endmodule

`default_nettype wire

// [verilog/dsos_top.sv]
// Drive stop option select: object dictionary entries for velocity
// unit scaling, quick stop deceleration and the three stop option
// codes, plus the sequencer that applies them on transitions.
// Assumes the power state machine, ramp generators and fieldbus
// stack run on sys_clk and talk to this block by one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"

module dsos_top
  import dsos_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           resetn,
  input  wire dsos_od_req_t   od_req,
  output dsos_od_rsp_t        od_rsp,
  input  wire logic           trans_valid,
  input  wire dsos_trans_t    trans_kind,
  input  wire logic           vel_mode,
  input  wire logic           ramp_done,
  input  wire logic           resume_req,
  input  wire logic           speed_valid,
  input  wire logic [31:0]    speed_in,
  output logic                speed_busy,
  output logic                rpm_valid,
  output logic                rpm_err,
  output logic [31:0]         rpm_out,
  output dsos_stop_cmd_t      stop_cmd
);

  typedef struct packed {
    logic [31:0]    scale_num;
    logic [31:0]    scale_den;
    logic [31:0]    qs_dspeed;
    logic [15:0]    qs_dtime;
    logic [15:0]    qs_action;
    logic [15:0]    shut_action;
    logic [15:0]    dis_action;
    dsos_od_rsp_t   rsp;
    dsos_state_t    state;
    dsos_action_t   act;
    dsos_stop_cmd_t cmd;
  } dsos_top_t;

  dsos_top_t s_q;
  dsos_top_t s_d;

  // ****************************************************************
  // Option code decoding
  // ****************************************************************
  function automatic dsos_action_t decode_action(input dsos_trans_t kind,
                                                 input logic [15:0] code);
    dsos_action_t a;
    a.brake     = DSOS_BRK_IMMEDIATE;
    a.target    = DSOS_TGT_SWITCH_ON_DISABLED;
    a.energized = 1'b0;
    a.defined   = 1'b1;
    if (kind == DSOS_TR_QUICK_STOP) begin
      unique case (code)
        `DSOS_CODE_IMMEDIATE:  a.brake = DSOS_BRK_IMMEDIATE;
        `DSOS_CODE_SLOW:       a.brake = DSOS_BRK_SLOW;
        `DSOS_CODE_QUICK:      a.brake = DSOS_BRK_QUICK;
        `DSOS_CODE_SLOW_HOLD: begin
          a.brake     = DSOS_BRK_SLOW;
          a.target    = DSOS_TGT_QUICK_STOP_ACTIVE;
          a.energized = 1'b1;
        end
        `DSOS_CODE_QUICK_HOLD: begin
          a.brake     = DSOS_BRK_QUICK;
          a.target    = DSOS_TGT_QUICK_STOP_ACTIVE;
          a.energized = 1'b1;
        end
        default: begin
          // Undefined code falls back to immediate stop
          a.defined = 1'b0;
        end
      endcase
    end else begin
      a.target = (kind == DSOS_TR_SHUTDOWN) ? DSOS_TGT_READY_TO_SWITCH_ON
                                            : DSOS_TGT_SWITCHED_ON;
      if (code == `DSOS_CODE_SLOW) begin
        a.brake = DSOS_BRK_SLOW;
      end else begin
        a.brake   = DSOS_BRK_COAST;
        a.defined = (code == `DSOS_CODE_COAST);
      end
    end
    return a;
  endfunction

  function automatic logic [15:0] code_for(input dsos_trans_t kind,
                                           input dsos_top_t s);
    unique case (kind)
      DSOS_TR_QUICK_STOP: code_for = s.qs_action;
      DSOS_TR_SHUTDOWN:   code_for = s.shut_action;
      default:            code_for = s.dis_action;
    endcase
  endfunction

  function automatic logic is_obj(input dsos_od_req_t r, input logic [15:0] idx,
                                  input logic [7:0] sub);
    is_obj = (r.index == idx) && (r.sub == sub);
  endfunction

  dsos_action_t new_act;
  assign new_act = decode_action(trans_kind, code_for(trans_kind, s_q));

  // ****************************************************************
  // Object access and stop sequencer
  // ****************************************************************
  always_comb begin
    logic hit;
    logic ro;
    logic mappable;
    hit      = 1'b0;
    ro       = 1'b0;
    mappable = 1'b0;
    s_d      = s_q;
    s_d.rsp.ack              = 1'b0;
    s_d.rsp.err              = 1'b0;
    s_d.cmd.state_chg        = 1'b0;
    s_d.cmd.resume_grant     = 1'b0;

    // Object dictionary access, one-cycle answer
    if (od_req.req) begin
      s_d.rsp.ack   = 1'b1;
      s_d.rsp.rdata = '0;
      if (is_obj(od_req, `DSOS_IDX_VEL_SCALE, `DSOS_SUB_COUNT) ||
          is_obj(od_req, `DSOS_IDX_VEL_QS_DECEL, `DSOS_SUB_COUNT)) begin
        hit = 1'b1;
        ro  = 1'b1;
        s_d.rsp.rdata[7:0] = `DSOS_RST_ENTRY_COUNT;
      end else if (is_obj(od_req, `DSOS_IDX_VEL_SCALE, `DSOS_SUB_FIRST)) begin
        hit      = 1'b1;
        mappable = 1'b1;
        s_d.rsp.rdata = s_q.scale_num;
        if (od_req.we) s_d.scale_num = od_req.wdata;
      end else if (is_obj(od_req, `DSOS_IDX_VEL_SCALE, `DSOS_SUB_SECOND)) begin
        hit      = 1'b1;
        mappable = 1'b1;
        s_d.rsp.rdata = s_q.scale_den;
        if (od_req.we) s_d.scale_den = od_req.wdata;
      end else if (is_obj(od_req, `DSOS_IDX_VEL_QS_DECEL, `DSOS_SUB_FIRST)) begin
        hit      = 1'b1;
        mappable = 1'b1;
        s_d.rsp.rdata = s_q.qs_dspeed;
        if (od_req.we) s_d.qs_dspeed = od_req.wdata;
      end else if (is_obj(od_req, `DSOS_IDX_VEL_QS_DECEL, `DSOS_SUB_SECOND)) begin
        hit      = 1'b1;
        mappable = 1'b1;
        s_d.rsp.rdata[15:0] = s_q.qs_dtime;
        if (od_req.we) s_d.qs_dtime = od_req.wdata[15:0];
      end else if (is_obj(od_req, `DSOS_IDX_QS_ACTION, `DSOS_SUB_COUNT)) begin
        hit = 1'b1;
        s_d.rsp.rdata[15:0] = s_q.qs_action;
        if (od_req.we && !od_req.pdo) s_d.qs_action = od_req.wdata[15:0];
      end else if (is_obj(od_req, `DSOS_IDX_SHUTDOWN_ACT, `DSOS_SUB_COUNT)) begin
        hit = 1'b1;
        s_d.rsp.rdata[15:0] = s_q.shut_action;
        if (od_req.we && !od_req.pdo) s_d.shut_action = od_req.wdata[15:0];
      end else if (is_obj(od_req, `DSOS_IDX_DISABLE_ACT, `DSOS_SUB_COUNT)) begin
        hit = 1'b1;
        s_d.rsp.rdata[15:0] = s_q.dis_action;
        if (od_req.we && !od_req.pdo) s_d.dis_action = od_req.wdata[15:0];
      end
      if (ro && od_req.we) begin
        s_d.rsp.rdata = '0;
      end
      s_d.rsp.err = !hit || (od_req.we && ro) || (od_req.pdo && !mappable);
    end

    // Stop sequencer
    unique case (s_q.state)
      DSOS_ST_IDLE, DSOS_ST_HELD: begin
        if (trans_valid) begin
          s_d.act              = new_act;
          s_d.cmd.brake        = new_act.brake;
          s_d.cmd.target       = new_act.target;
          s_d.cmd.code_err     = !new_act.defined;
          s_d.cmd.resume_ok    = 1'b0;
          s_d.cmd.energized    = new_act.energized;
          // Velocity mode quick ramp (codes 2 and 6) uses the stored ratio
          s_d.cmd.use_vel_ratio = vel_mode && (new_act.brake == DSOS_BRK_QUICK);
          s_d.cmd.dec_speed    = s_q.qs_dspeed;
          s_d.cmd.dec_time     = s_q.qs_dtime;
          if (new_act.brake == DSOS_BRK_SLOW || new_act.brake == DSOS_BRK_QUICK) begin
            s_d.cmd.ramp_req = 1'b1;
            s_d.state        = DSOS_ST_RAMP;
          end else begin
            s_d.cmd.ramp_req  = 1'b0;
            s_d.cmd.state_chg = 1'b1;
            s_d.state         = DSOS_ST_IDLE;
          end
        end else if (s_q.state == DSOS_ST_HELD && resume_req) begin
          s_d.cmd.resume_grant = 1'b1;
          s_d.cmd.resume_ok    = 1'b0;
          s_d.cmd.energized    = 1'b0;
          s_d.cmd.brake        = DSOS_BRK_NONE;
          s_d.state            = DSOS_ST_IDLE;
        end
      end
      DSOS_ST_RAMP: begin
        if (ramp_done) begin
          s_d.cmd.ramp_req      = 1'b0;
          s_d.cmd.use_vel_ratio = 1'b0;
          s_d.cmd.state_chg     = 1'b1;
          if (s_q.act.energized) begin
            s_d.cmd.resume_ok = 1'b1;
            s_d.state         = DSOS_ST_HELD;
          end else begin
            s_d.state = DSOS_ST_IDLE;
          end
        end
      end
      default: begin
        s_d.state = DSOS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_q             <= '0;
      s_q.scale_num   <= `DSOS_RST_SCALE_NUM;
      s_q.scale_den   <= `DSOS_RST_SCALE_DEN;
      s_q.qs_dspeed   <= `DSOS_RST_QS_DSPEED;
      s_q.qs_dtime    <= `DSOS_RST_QS_DTIME;
      s_q.qs_action   <= `DSOS_RST_QS_ACTION;
      s_q.shut_action <= `DSOS_RST_SHUTDOWN_ACT;
      s_q.dis_action  <= `DSOS_RST_DISABLE_ACT;
      s_q.state       <= DSOS_ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign od_rsp   = s_q.rsp;
  assign stop_cmd = s_q.cmd;

  // ****************************************************************
  // Speed conversion to rpm
  // ****************************************************************
  dsos_scale #(
    .WIDTH (32)
  ) u_scale (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .start    (speed_valid),
    .speed_in (speed_in),
    .num      (s_q.scale_num),
    .den      (s_q.scale_den),
    .busy     (speed_busy),
    .done     (rpm_valid),
    .div_zero (rpm_err),
    .result   (rpm_out)
  );

endmodule

`default_nettype wire

// [bench/dsos_top_chk.sv]
// Checker of the drive stop option select block, bound to dsos_top.
// Assumes one clock domain, sys_clk, with resetn active low.
`timescale 1ns/1ps
`default_nettype none

module dsos_top_chk
  import dsos_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           resetn,
  input wire dsos_od_req_t   od_req,
  input wire dsos_od_rsp_t   od_rsp,
  input wire logic           trans_valid,
  input wire dsos_trans_t    trans_kind,
  input wire logic           vel_mode,
  input wire logic           ramp_done,
  input wire logic           resume_req,
  input wire logic           speed_valid,
  input wire logic [31:0]    speed_in,
  input wire logic           speed_busy,
  input wire logic           rpm_valid,
  input wire logic           rpm_err,
  input wire logic [31:0]    rpm_out,
  input wire dsos_stop_cmd_t stop_cmd
);
  // ****************************************************************
  // Sequences
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    speed_valid && !speed_busy;
  endsequence
  sequence s_ramp_end;
    stop_cmd.ramp_req && ramp_done;
  endsequence
  sequence s_resumed;
    stop_cmd.resume_grant && !stop_cmd.energized;
  endsequence

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ack_next: assert property (od_req.req |=> od_rsp.ack)
    else $error("no answer after object request");
  a_count_ro: assert property (
    od_req.req && od_req.we && od_req.index == 16'h604C && od_req.sub == 8'h00
    |=> od_rsp.err)
    else $error("entry count write not refused");
  a_opt_no_pdo: assert property (
    od_req.req && od_req.pdo && od_req.index inside {16'h605A, 16'h605B, 16'h605C}
    |=> od_rsp.err)
    else $error("option code process data access not refused");
  a_rpm_answer: assert property (s_start |-> ##[1:65] rpm_valid)
    else $error("speed conversion gave no result");
  a_ramp_end: assert property (
    s_ramp_end |=> stop_cmd.state_chg && !stop_cmd.ramp_req)
    else $error("ramp end without state change");
  a_ramp_cause: assert property (
    $rose(stop_cmd.ramp_req) |-> $past(trans_valid))
    else $error("ramp started without transition");
  a_hold_state: assert property (
    stop_cmd.energized && !stop_cmd.resume_grant
    |-> stop_cmd.target == DSOS_TGT_QUICK_STOP_ACTIVE
    && stop_cmd.brake inside {DSOS_BRK_SLOW, DSOS_BRK_QUICK})
    else $error("energized hold with wrong target");
  a_resume_ok: assert property (
    !trans_valid && resume_req && stop_cmd.resume_ok |=> s_resumed)
    else $error("resume not granted");
  a_resume_cause: assert property (
    stop_cmd.resume_grant |-> $past(resume_req) && $past(stop_cmd.resume_ok))
    else $error("resume granted without request");
  a_vel_ratio: assert property (
    stop_cmd.use_vel_ratio && stop_cmd.ramp_req |-> stop_cmd.brake == DSOS_BRK_QUICK)
    else $error("velocity ratio used off the quick ramp");
  a_leave_code: assert property (
    stop_cmd.state_chg && stop_cmd.target inside
    {DSOS_TGT_READY_TO_SWITCH_ON, DSOS_TGT_SWITCHED_ON}
    |-> stop_cmd.brake inside {DSOS_BRK_COAST, DSOS_BRK_SLOW} && !stop_cmd.energized)
    else $error("wrong action on leaving operation");
  a_qs_end: assert property (
    stop_cmd.state_chg && stop_cmd.target == DSOS_TGT_SWITCH_ON_DISABLED
    |-> stop_cmd.brake inside {DSOS_BRK_IMMEDIATE, DSOS_BRK_SLOW, DSOS_BRK_QUICK})
    else $error("wrong action before switch on disabled");
endmodule

bind dsos_top dsos_top_chk u_chk (.sys_clk, .resetn, .od_req, .od_rsp, .trans_valid,
  .trans_kind, .vel_mode, .ramp_done, .resume_req, .speed_valid, .speed_in, .speed_busy,
  .rpm_valid, .rpm_err, .rpm_out, .stop_cmd);

`default_nettype wire

// [bench/dsos_master.sv]
// Fieldbus master model issuing object dictionary requests.
// Assumes the device answers one cycle after taking a request.
`timescale 1ns/1ps
`default_nettype none

module dsos_master
  import dsos_pkg::*;
(
  input  wire logic         sys_clk,
  output dsos_od_req_t      od_req,
  input  wire dsos_od_rsp_t od_rsp
);
  initial od_req = '0;

  // One request; released fields show the inverse
  task automatic access(input logic we, input logic pdo, input logic [15:0] idx,
                        input logic [7:0] sub, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
    @(posedge sys_clk);
    #1 od_req = '{1'b1, we, pdo, idx, sub, wd};
    @(posedge sys_clk);
    #1 od_req = '{1'b0, ~we, ~pdo, ~idx, ~sub, ~wd};
    rd = od_rsp.rdata;
    er = (od_rsp.ack === 1'b1) ? od_rsp.err : 1'bx;
  endtask
endmodule

`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench of dsos_top with a fieldbus master model.
// Assumes dsos_pkg compiled and the checker bound to dsos_top.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import dsos_pkg::*;
  logic           sys_clk, resetn, trans_valid, vel_mode, ramp_done, resume_req;
  logic           speed_valid, speed_busy, rpm_valid, rpm_err, er;
  logic [31:0]    speed_in, rpm_out, rd, num, den;
  dsos_trans_t    trans_kind;
  dsos_od_req_t   od_req;
  dsos_od_rsp_t   od_rsp;
  dsos_stop_cmd_t stop_cmd;
  int             n_errors = 0;
  int             num_checks = 0;
  int             cycles = 0;
  logic [15:0]    idx_t [6] = '{16'h604C, 16'h604C, 16'h604C, 16'h605A, 16'h605B, 16'h605C};
  logic [7:0]     sub_t [6] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00};
  logic [31:0]    rst_t [6] = '{32'h2, 32'h1, 32'h1, 32'h2, 32'h1, 32'h1};
  logic [15:0]    qs_t [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006, 16'h0003};

  dsos_top dut (.sys_clk(sys_clk), .resetn(resetn), .od_req(od_req), .od_rsp(od_rsp),
    .trans_valid(trans_valid), .trans_kind(trans_kind), .vel_mode(vel_mode),
    .ramp_done(ramp_done), .resume_req(resume_req), .speed_valid(speed_valid),
    .speed_in(speed_in), .speed_busy(speed_busy), .rpm_valid(rpm_valid),
    .rpm_err(rpm_err), .rpm_out(rpm_out), .stop_cmd(stop_cmd));
  dsos_master mst (.sys_clk(sys_clk), .od_req(od_req), .od_rsp(od_rsp));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic acc(logic we, logic pdo, logic [15:0] idx, logic [7:0] sub, logic [31:0] wd);
    mst.access(we, pdo, idx, sub, wd, rd, er);
  endtask

  function automatic dsos_action_t exp_act(dsos_trans_t k, logic [15:0] c);
    exp_act = '{DSOS_BRK_IMMEDIATE, DSOS_TGT_SWITCH_ON_DISABLED, 1'b0, 1'b0};
    if (k != DSOS_TR_QUICK_STOP) begin
      exp_act.target = (k == DSOS_TR_SHUTDOWN) ? DSOS_TGT_READY_TO_SWITCH_ON
                                                : DSOS_TGT_SWITCHED_ON;
      exp_act.brake = (c == 16'h0001) ? DSOS_BRK_SLOW : DSOS_BRK_COAST;
      exp_act.defined = (c <= 16'h0001);
    end else if (c inside {16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006}) begin
      exp_act.defined = 1'b1;
      if (c != 16'h0000) exp_act.brake = c[0] ? DSOS_BRK_SLOW : DSOS_BRK_QUICK;
      exp_act.energized = c[2];
      if (c[2]) exp_act.target = DSOS_TGT_QUICK_STOP_ACTIVE;
    end
  endfunction

  function automatic logic [31:0] exp_rpm(logic [31:0] s, logic [31:0] n, logic [31:0] d);
    longint p;
    p = longint'(signed'(s)) * longint'(signed'(n));
    return (d == 32'h0) ? 32'h0 : 32'(p / longint'(signed'(d)));
  endfunction

  task automatic do_trans(dsos_trans_t k, logic [15:0] c, logic v);
    dsos_action_t e;
    logic         ramp;
    e = exp_act(k, c);
    ramp = e.brake inside {DSOS_BRK_SLOW, DSOS_BRK_QUICK};
    acc(1'b1, 1'b0, 16'h605A + 16'(k), 8'h00, {16'h0000, c});
    @(posedge sys_clk);
    #1 trans_valid = 1'b1;
    trans_kind = k;
    vel_mode = v;
    @(posedge sys_clk);
    #1 trans_valid = 1'b0;
    chk("brake", 32'(stop_cmd.brake), 32'(e.brake));
    chk("target", 32'(stop_cmd.target), 32'(e.target));
    chk("energized", 32'(stop_cmd.energized), 32'(e.energized));
    chk("code_err", 32'(stop_cmd.code_err), 32'(!e.defined));
    chk("ramp_req", 32'(stop_cmd.ramp_req), 32'(ramp));
    if (ramp) begin
      chk("use_vel_ratio", 32'(stop_cmd.use_vel_ratio), 32'(v && c[1]));
      if (v && c[1]) begin
        chk("dec_speed", stop_cmd.dec_speed, 32'h0000_1388);
        chk("dec_time", 32'(stop_cmd.dec_time), 32'h1);
      end
      repeat (2) @(posedge sys_clk);
      #1 ramp_done = 1'b1;
      @(posedge sys_clk);
      #1 ramp_done = 1'b0;
    end
    chk("state_chg", 32'(stop_cmd.state_chg), 32'h1);
    if (e.energized) begin
      chk("resume_ok", 32'(stop_cmd.resume_ok), 32'h1);
      resume_req = 1'b1;
      @(posedge sys_clk);
      #1 resume_req = 1'b0;
      chk("resume_grant", 32'(stop_cmd.resume_grant), 32'h1);
    end
    $display("test transition %0d code %0h done", k, c);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************************************
  // Clock, timeout and tests
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    resetn = 1'b0;
    {trans_valid, vel_mode, ramp_done, resume_req, speed_valid} = '0;
    trans_kind = DSOS_TR_QUICK_STOP;
    speed_in = 32'h0;
    void'($urandom(10689));
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1'b1;
    foreach (idx_t[i]) begin
      acc(1'b0, 1'b0, idx_t[i], sub_t[i], 32'h0);
      chk("preset", rd, rst_t[i]);
      chk("preset_err", 32'(er), 32'h0);
    end
    acc(1'b1, 1'b0, 16'h604C, 8'h00, 32'h5);
    chk("count_ro_err", 32'(er), 32'h1);
    acc(1'b1, 1'b1, 16'h605B, 8'h00, 32'h0);
    chk("pdo_err", 32'(er), 32'h1);
    acc(1'b0, 1'b0, 16'h605B, 8'h00, 32'h0);
    chk("shutdown_kept", rd, 32'h1);
    acc(1'b0, 1'b0, 16'h6000, 8'h00, 32'h0);
    chk("unmapped_err", 32'(er), 32'h1);
    $display("test objects done");
    for (int i = 0; i < 4; i++) begin
      num = (i == 0) ? 32'd60 : $urandom_range(1000, 1);
      den = (i == 0) ? 32'd1 : (i == 3) ? 32'd0 : $urandom_range(50, 1);
      if (i == 2) den = -den;
      acc(1'b1, 1'b1, 16'h604C, 8'h01, num);
      acc(1'b1, 1'b1, 16'h604C, 8'h02, den);
      acc(1'b0, 1'b0, 16'h604C, 8'h01, 32'h0);
      chk("numerator", rd, num);
      @(posedge sys_clk);
      #1 speed_valid = 1'b1;
      speed_in = $urandom_range(200000) - 100000;
      @(posedge sys_clk);
      #1 speed_valid = 1'b0;
      chk("speed_busy", 32'(speed_busy), 32'(den != 32'h0));
      for (int w = 0; w < 80 && rpm_valid !== 1'b1; w++) begin
        @(posedge sys_clk);
        #1;
      end
      chk("rpm_valid", 32'(rpm_valid), 32'h1);
      chk("rpm_out", rpm_out, exp_rpm(speed_in, num, den));
      chk("rpm_err", 32'(rpm_err), 32'(den == 32'h0));
      $display("test conversion %0d done", i);
    end
    foreach (qs_t[i]) do_trans(DSOS_TR_QUICK_STOP, qs_t[i], i > 2);
    for (int k = 1; k < 3; k++) begin
      do_trans(dsos_trans_t'(k), 16'h0000, 1'b0);
      do_trans(dsos_trans_t'(k), 16'h0001, 1'b1);
    end
    stop_test();
  end
endmodule

`default_nettype wire
